// *** verilog/eeprom_led_regs.v ***
// EEPROM direct port control and second LED function select registers on classic Wishbone
//
// What this block does
// - Port disabled: data, clock, select ignored.
// - Shift-busy bit 3 drives pin when enabled.
// - Disabled port keeps last shift-busy value.
// - Bit 2 drives EEPROM chip select.
// - Bit 1 drives EEPROM shift clock.
// - Bit 0 writes data in, reads out.
// - Link register bits 14..0 reserved, read zero.
// - LED shows OR of enabled functions.
// - Reset selects receive activity plus stretcher.
// - Bits 14..8 and 6 read zero.
// - Bit 7 stretches each LED event.
// - Bit 5 limits receive to address matches.
// - Bit 4 adds transmit activity.
// - Enable remaps boot data port low bits.
// - Bits 3..0: polarity, receive, jabber, collision.
`include "eeprom_led_defs.vh"

module eeprom_led_regs #(
  parameter STRETCH_CYCLES = `STRETCH_CYCLES,
  parameter STRETCH_CW     = 12
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  // Controller state
  input  wire        ctrl_stopped,
  // Serial EEPROM and shift logic pins
  output wire        eeprom_select,
  output wire        serial_clock_pin,
  output wire        serial_data_in_pin,
  input  wire        serial_data_out_pin,
  output wire        shift_busy_pin,
  // Boot memory data port low bits, remapped while enabled
  input  wire [2:0]  boot_memory_data_port_in,
  output wire [2:0]  boot_memory_data_port_out,
  output wire [2:0]  boot_memory_data_port_oe_n,
  // Network activity events (same clock domain)
  input  wire        link_ok,
  input  wire        evt_collision,
  input  wire        evt_jabber,
  input  wire        evt_receive,
  input  wire        evt_receive_match,
  input  wire        evt_rx_polarity_ok,
  input  wire        evt_transmit,
  output reg         second_led_pin
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [4:0] ee_ctrl_r;
  reg [7:0] led_sel_r;
  reg       busy_r;
  wire      ee_data_sync;
  wire      port_en;
  wire      raw_indication_state;
  wire      stretched;
  wire      led_nxt;
  wire      rx_term;

  assign port_en = ee_ctrl_r[`EE_BIT_ENABLE];

  // Data out from the EEPROM is a pin: synchronise before reading
  sync2 #(
    .W (1)
  ) u_do_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      (serial_data_out_pin),
    .q      (ee_data_sync)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire hit_ee  = (wb_adr_i == `OFS_EEPROM_CTRL);
  wire hit_lnk = (wb_adr_i == `OFS_LINK_LED);
  wire hit_led = (wb_adr_i == `OFS_LED_SELECT);
  wire mapped  = hit_ee | hit_lnk | hit_led;
  // Writes land at the edge where the master samples ack, never earlier
  wire wr_lo   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Unmapped addresses are acked and read zero; error never raised
  assign wb_err_o = 1'b0;

  // Write path; software is expected to write enable only when stopped
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ee_ctrl_r <= `EE_CTRL_RESET;
      led_sel_r <= `LED_SEL_RESET;
    end else if (ce) begin
      if (wr_lo && hit_ee) begin
        ee_ctrl_r <= wb_dat_i[4:0];
      end
      if (wr_lo && hit_led) begin
        // Bit 6 is reserved and stored as zero
        led_sel_r <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      end
    end
  end

  // Ack one cycle after request, dropped the next cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req;
    end
  end

  // Read data captured with the ack
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      if (req && !wb_we_i) begin
        wb_dat_o <= 32'h00000000;
        if (hit_ee) begin
          wb_dat_o[4:1] <= ee_ctrl_r[4:1];
          wb_dat_o[`EE_BIT_DATA] <= ee_data_sync;
        end else if (hit_lnk) begin
          // Reserved low bits read as zero here
          wb_dat_o[`LINK_BIT_STATE] <= link_ok;
        end else if (hit_led) begin
          wb_dat_o[7:0] <= led_sel_r;
          wb_dat_o[`LED_BIT_RAW] <= raw_indication_state;
        end else if (!mapped) begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // EEPROM pins
  // --------------------------------------------------------------------------
  // Controls drive only while enabled; low otherwise
  assign eeprom_select      = port_en & ee_ctrl_r[`EE_BIT_SELECT];
  assign serial_clock_pin   = port_en & ee_ctrl_r[`EE_BIT_SCLK];
  assign serial_data_in_pin = port_en & ee_ctrl_r[`EE_BIT_DATA];

  // Shift-busy follows the written bit only in a write that enables the port
  // Any other write leaves it, so a disabled port keeps the last value
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (wr_lo && hit_ee && wb_dat_i[`EE_BIT_ENABLE]) begin
        busy_r <= wb_dat_i[`EE_BIT_SHIFT_BUSY];
      end
    end
  end

  assign shift_busy_pin = busy_r;

  // Boot port low bits become clock, data in (driven) and data out (input)
  assign boot_memory_data_port_out  = {1'b0, serial_data_in_pin, serial_clock_pin};
  assign boot_memory_data_port_oe_n = port_en ? 3'b100 : 3'b111;

  // --------------------------------------------------------------------------
  // Second LED
  // --------------------------------------------------------------------------
  // Receive optionally qualified by address match
  assign rx_term = led_sel_r[`LED_BIT_RECEIVE] &
                   (led_sel_r[`LED_BIT_MATCH] ? evt_receive_match : evt_receive);

  // OR of every enabled function
  assign raw_indication_state =
      (led_sel_r[`LED_BIT_COLLISION]   & evt_collision)      |
      (led_sel_r[`LED_BIT_JABBER]      & evt_jabber)         |
      rx_term                                                |
      (led_sel_r[`LED_BIT_RX_POLARITY] & evt_rx_polarity_ok) |
      (led_sel_r[`LED_BIT_TRANSMIT]    & evt_transmit);

  pulse_stretch #(
    .CW     (STRETCH_CW),
    .CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .trig      (raw_indication_state),
    .stretched (stretched)
  );

  assign led_nxt = led_sel_r[`LED_BIT_STRETCH] ? stretched : raw_indication_state;

  // Registered LED drive, active high
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_led_pin <= 1'b0;
    end else if (ce) begin
      second_led_pin <= led_nxt;
    end
  end

  // Unused boot port input bits are kept for pin symmetry
  wire unused_ok = &{1'b0, boot_memory_data_port_in, ctrl_stopped};

endmodule // eeprom_led_regs

// *** verilog/eeprom_led_defs.vh ***
// Register offsets, field positions, reset values and timing counts for the EEPROM port and LED slice
`ifndef EEPROM_LED_DEFS_VH
`define EEPROM_LED_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------------------
`define OFS_EEPROM_CTRL      4'h0
`define OFS_LINK_LED         4'h4
`define OFS_LED_SELECT       4'h8

// ----------------------------------------------------------------------------
// eeprom_direct_port_control fields
// ----------------------------------------------------------------------------
`define EE_BIT_DATA          0
`define EE_BIT_SCLK          1
`define EE_BIT_SELECT        2
`define EE_BIT_SHIFT_BUSY    3
`define EE_BIT_ENABLE        4
`define EE_CTRL_RESET        5'h00

// ----------------------------------------------------------------------------
// link_led_state fields
// ----------------------------------------------------------------------------
`define LINK_BIT_STATE       15

// ----------------------------------------------------------------------------
// second_led_function_select fields
// ----------------------------------------------------------------------------
`define LED_BIT_COLLISION    0
`define LED_BIT_JABBER       1
`define LED_BIT_RECEIVE      2
`define LED_BIT_RX_POLARITY  3
`define LED_BIT_TRANSMIT     4
`define LED_BIT_MATCH        5
`define LED_BIT_STRETCH      7
`define LED_BIT_RAW          15
`define LED_SEL_RESET        8'h84

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ          50000000
`define STRETCH_TIME_US      50
`define STRETCH_CYCLES       ((`STRETCH_TIME_US * (`CLK_FREQ_HZ / 1000000)))

`endif

// *** verilog/sync2.v ***
// Two-flop synchroniser for asynchronous pin inputs
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         ce,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= {W{1'b0}};
      stable_r <= {W{1'b0}};
    end else if (ce) begin
      meta_r   <= d;
      stable_r <= meta_r;
    end
  end

  assign q = stable_r;
endmodule // sync2

// *** verilog/pulse_stretch.v ***
// Retriggerable pulse stretcher for the LED output
module pulse_stretch #(
  parameter CW     = 12,
  parameter CYCLES = 2500
) (
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  input  wire trig,
  output wire stretched
);
  // Count is cut to the counter width on purpose; CW must hold CYCLES - 1
  localparam integer  LOAD_FULL = CYCLES - 1;
  localparam [CW-1:0] LOAD      = LOAD_FULL[CW-1:0];
  reg [CW-1:0] cnt_r;

  // Reload on every event so a burst keeps the LED lit
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {CW{1'b0}};
    end else if (ce) begin
      if (trig) begin
        cnt_r <= LOAD;
      end else if (cnt_r != {CW{1'b0}}) begin
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign stretched = trig | (cnt_r != {CW{1'b0}});
endmodule // pulse_stretch

// *** testbench/eeprom_led_regs_checker.sv ***
// Concurrent checks on the EEPROM port and LED register slice
module eeprom_led_regs_checker (
  input logic        clk,
  input logic        arst_n,
  input logic        ce,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [3:0]  wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        eeprom_select,
  input logic        serial_clock_pin,
  input logic        serial_data_in_pin,
  input logic        shift_busy_pin,
  input logic [2:0]  boot_memory_data_port_out,
  input logic [2:0]  boot_memory_data_port_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // -----------------------------------------------------------------
  // Port state seen through the remapped boot lanes
  // -----------------------------------------------------------------
  wire en     = boot_memory_data_port_oe_n == 3'h4;
  wire en_off = boot_memory_data_port_oe_n == 3'h7;
  wire rd_ack = wb_ack_o && !wb_we_i;
  a_select_gated:
    assert property (eeprom_select |-> en) else $error("select driven while disabled");
  a_clock_gated:
    assert property (serial_clock_pin |-> en) else $error("shift clock driven while disabled");
  a_data_gated:
    assert property (serial_data_in_pin |-> en) else $error("data in driven while disabled");
  a_remap_lanes:
    assert property (en |-> boot_memory_data_port_out == {1'h0, serial_data_in_pin, serial_clock_pin})
      else $error("boot lanes not remapped");
  a_busy_gated:
    assert property ($rose(shift_busy_pin) |-> en) else $error("shift busy raised while disabled");
  a_busy_kept:
    assert property (en_off && $past(en_off) && !wb_ack_o |-> $stable(shift_busy_pin))
      else $error("shift busy moved while disabled");
  a_ack_timing:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o) else $error("ack late");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_select_reserved:
    assert property (rd_ack && wb_adr_i == 4'h8 |-> wb_dat_o[14:8] == 7'h00 && !wb_dat_o[6])
      else $error("reserved select bits not zero");
  a_link_reserved:
    assert property (rd_ack && wb_adr_i == 4'h4 |-> wb_dat_o[14:0] == 15'h0000)
      else $error("reserved link bits not zero");
endmodule // eeprom_led_regs_checker

bind eeprom_led_regs eeprom_led_regs_checker eeprom_led_regs_checker_i (
  .clk                        (clk),
  .arst_n                     (arst_n),
  .ce                         (ce),
  .wb_cyc_i                   (wb_cyc_i),
  .wb_stb_i                   (wb_stb_i),
  .wb_we_i                    (wb_we_i),
  .wb_adr_i                   (wb_adr_i),
  .wb_dat_o                   (wb_dat_o),
  .wb_ack_o                   (wb_ack_o),
  .eeprom_select              (eeprom_select),
  .serial_clock_pin           (serial_clock_pin),
  .serial_data_in_pin         (serial_data_in_pin),
  .shift_busy_pin             (shift_busy_pin),
  .boot_memory_data_port_out  (boot_memory_data_port_out),
  .boot_memory_data_port_oe_n (boot_memory_data_port_oe_n)
);

// *** testbench/eeprom_model.sv ***
// Behavioural serial EEPROM answering on the data-out line
module eeprom_model (
  input  logic clk,
  input  logic eeprom_select,
  input  logic serial_clock_pin,
  input  logic serial_data_in_pin,
  output logic serial_data_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sk_r = 1'h0;
  logic do_r = 1'h0;
  assign serial_data_out_pin = do_r;
  // Echo inverted data on each shift clock rise; toggle when not selected,
  // so a read of a deselected part never looks stable
  always @(posedge clk) begin
    sk_r <= serial_clock_pin;
    if (!eeprom_select)
      do_r <= ~do_r;
    else if (serial_clock_pin && !sk_r)
      do_r <= ~serial_data_in_pin;
  end
endmodule // eeprom_model

// *** testbench/eeprom_led_regs_tb.sv ***
// Register-level testbench for the EEPROM port and LED slice
module eeprom_led_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ctrl_stopped = 1, link_ok = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, rd;
  logic [5:0] ev = 0;
  logic [2:0] boot_memory_data_port_in = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, wb_err_o, eeprom_select, serial_clock_pin, serial_data_in_pin, serial_data_out_pin;
  wire shift_busy_pin, second_led_pin;
  wire [2:0] boot_memory_data_port_out, boot_memory_data_port_oe_n;
  wire evt_collision = ev[0], evt_jabber = ev[1], evt_receive = ev[2], evt_rx_polarity_ok = ev[3];
  wire evt_transmit = ev[4], evt_receive_match = ev[5];
  wire [9:0] pins = {shift_busy_pin, eeprom_select, serial_clock_pin, serial_data_in_pin,
                     boot_memory_data_port_oe_n, boot_memory_data_port_out};
  int error_cnt = 0, cmp_count = 0;
  // Short stretch so the LED hold time is counted exactly
  localparam int STRETCH = 8;

  eeprom_led_regs #(
    .STRETCH_CYCLES (STRETCH)
  ) eeprom_led_regs_i (
    .clk                        (clk),
    .arst_n                     (arst_n),
    .ce                         (ce),
    .wb_cyc_i                   (wb_cyc_i),
    .wb_stb_i                   (wb_stb_i),
    .wb_we_i                    (wb_we_i),
    .wb_adr_i                   (wb_adr_i),
    .wb_sel_i                   (wb_sel_i),
    .wb_dat_i                   (wb_dat_i),
    .wb_dat_o                   (wb_dat_o),
    .wb_ack_o                   (wb_ack_o),
    .wb_err_o                   (wb_err_o),
    .ctrl_stopped               (ctrl_stopped),
    .eeprom_select              (eeprom_select),
    .serial_clock_pin           (serial_clock_pin),
    .serial_data_in_pin         (serial_data_in_pin),
    .serial_data_out_pin        (serial_data_out_pin),
    .shift_busy_pin             (shift_busy_pin),
    .boot_memory_data_port_in   (boot_memory_data_port_in),
    .boot_memory_data_port_out  (boot_memory_data_port_out),
    .boot_memory_data_port_oe_n (boot_memory_data_port_oe_n),
    .link_ok                    (link_ok),
    .evt_collision              (evt_collision),
    .evt_jabber                 (evt_jabber),
    .evt_receive                (evt_receive),
    .evt_receive_match          (evt_receive_match),
    .evt_rx_polarity_ok         (evt_rx_polarity_ok),
    .evt_transmit               (evt_transmit),
    .second_led_pin             (second_led_pin)
  );
  eeprom_model eeprom_model_i (
    .clk                 (clk),
    .eeprom_select       (eeprom_select),
    .serial_clock_pin    (serial_clock_pin),
    .serial_data_in_pin  (serial_data_in_pin),
    .serial_data_out_pin (serial_data_out_pin)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic single cycle; waits for ack with a bound, then releases
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      error_cnt++;
      close_out();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    ticks(10);
    arst_n <= 1;
    xfer(0, 4'h8, 0);
    chk("led_select", 32'h84, rd);
    xfer(1, 4'h0, 32'h0f);
    ticks(1);
    chk("pins_disabled", 10'h038, pins);
    xfer(1, 4'h0, 32'h1f);
    ticks(1);
    chk("pins_enabled", 10'h3e3, pins);
    for (int b = 0; b < 2; b++) begin
      xfer(1, 4'h0, 32'h14 | b);
      xfer(1, 4'h0, 32'h16 | b);
      ticks(4);
      xfer(0, 4'h0, 0);
      chk("data_out", {31'h0, ~b[0]}, rd & 32'h1);
    end
    xfer(1, 4'h0, 32'h18);
    xfer(1, 4'h0, 32'h08);
    ticks(1);
    chk("busy_kept", 10'h238, pins);
    // Each function alone, without stretching
    for (int i = 0; i < 5; i++) begin
      xfer(1, 4'h8, 32'h1 << i);
      ev <= 6'h1f & ~(6'h1 << i);
      ticks(3);
      chk("led_others", 0, second_led_pin);
      ev <= 6'h1 << i;
      ticks(3);
      chk("led_on", 1, second_led_pin);
      xfer(0, 4'h8, 0);
      chk("raw_state", 32'h8000 | (32'h1 << i), rd);
      ev <= 0;
      ticks(3);
      chk("led_off", 0, second_led_pin);
    end
    xfer(1, 4'h8, 32'h24);
    ev <= 6'h04;
    ticks(3);
    chk("led_unmatched", 0, second_led_pin);
    ev <= 6'h24;
    ticks(3);
    chk("led_matched", 1, second_led_pin);
    ev <= 0;
    xfer(1, 4'h8, 32'h84);
    ev <= 6'h04;
    ticks(1);
    ev <= 0;
    // One event cycle keeps the pin lit for exactly STRETCH cycles
    ticks(STRETCH);
    chk("led_stretched", 1, second_led_pin);
    ticks(1);
    chk("led_expired", 0, second_led_pin);
    xfer(1, 4'h8, 32'hbf);
    xfer(0, 4'h8, 0);
    chk("select_reserved", 32'hbf, rd);
    xfer(0, 4'h4, 0);
    chk("link_idle", 0, rd & 32'h8000);
    link_ok <= 1;
    xfer(0, 4'h4, 0);
    chk("link_state", 32'h8000, rd & 32'h8000);
    xfer(0, 4'hc, 0);
    chk("unmapped", 0, rd);
    chk("bus_error", 0, wb_err_o);
    // Clock enable low freezes the LED path
    xfer(1, 4'h8, 32'h10);
    ce <= 0;
    ev <= 6'h10;
    ticks(3);
    chk("led_frozen", 0, second_led_pin);
    ce <= 1;
    ticks(3);
    chk("led_resumed", 1, second_led_pin);
    // Reset in mid-run restores the defaults
    ev <= 0;
    arst_n <= 0;
    ticks(2);
    chk("pins_reset", 10'h038, pins);
    arst_n <= 1;
    xfer(0, 4'h8, 0);
    chk("select_reset", 32'h84, rd);
    close_out();
  end
endmodule // eeprom_led_regs_tb
